// [hdl/fan_ctrl_map.vh]
// Notes on behaviour
// - three modes, all steer only duty
// - auto mode maps temperature to duty alone
// - speed mode holds tacho_in period at target
// - direct mode uses host duty unchanged
// - 8-bit duty, zero off, full on
// - strap low fast range, high slow
// - address pins latched only at reset
// - fan drive open-drain, pulls low only
// - fan speed measured from tacho_in pulses
// - critical alarm on limit or sensor fault
// - thermal pin low above thermal limit
// - external pull low flags, forces full
// - fan failure alarm pulls low
// - alert output asserted on error conditions
// - bus data open-drain, clock input only
// - bus ignored 1.5 ms after reset
// - tacho_in timed with 100 kHz reference
// - converter runs only while start set
`ifndef FAN_CTRL_MAP_VH
`define FAN_CTRL_MAP_VH
`define CLK_HZ 100000000
`define TACHO_IN_REF_HZ 100000
`define BOOT_US 1500
`define FAST_PWM_HZ 25000
`define SLOW_PWM_HZ 40
`define MODE_AUTO 2'h0
`define MODE_SPEED 2'h1
`define MODE_DIRECT 2'h2
`define DUTY_FULL 8'hFF
`define FAIL_COUNT 16'hFFFF
`endif

// [hdl/thermal_fan_pwm_control.v]
`include "fan_ctrl_map.vh"
`timescale 1ns/100ps
`default_nettype none
module thermal_fan_pwm_control #(
   parameter BOOT_CYCLES = (`CLK_HZ / 1000000) * `BOOT_US,
   parameter REF_DIV = `CLK_HZ / `TACHO_IN_REF_HZ
) (
   input wire mclk,
   input wire srst,
   input wire [1:0] mode_sel,
   input wire [7:0] host_duty,
   input wire [15:0] target_period,
   input wire [7:0] temperature,
   input wire temp_valid,
   input wire sensor_fault,
   input wire [7:0] auto_start_temp,
   input wire [7:0] auto_slope,
   input wire [7:0] critical_limit,
   input wire [7:0] thermal_limit,
   input wire [7:0] alert_limit,
   input wire alert_enable,
   input wire conv_start,
   input wire freq_range_sel,
   input wire addr_sel_hi,
   input wire addr_sel_lo,
   input wire tacho_in,
   input wire thermal_limit_in,
   input wire smb_clk_in,
   input wire smb_data_in,
   output reg fan_drive_oe,
   output reg critical_temp_oe,
   output reg thermal_limit_oe,
   output reg fan_failure_oe,
   output reg smb_alert_oe,
   output reg smb_data_oe,
   output reg external_thermal_request_flag,
   output reg [15:0] tacho_in_period,
   output reg [7:0] duty_now,
   output reg slow_range,
   output reg [1:0] bus_addr_sel,
   output reg bus_ready,
   output reg conv_run,
   output reg [1:0] smb_sync
);
   localparam integer FAST_DIV_I = `CLK_HZ / (`FAST_PWM_HZ * 256);
   localparam integer SLOW_DIV_I = `CLK_HZ / (`SLOW_PWM_HZ * 256);
   localparam [15:0] FAST_DIV = FAST_DIV_I[15:0];
   localparam [15:0] SLOW_DIV = SLOW_DIV_I[15:0];
   localparam integer SYNC_W = 7;

   reg tacho_in_d;
   reg strap_done;
   reg [2:0] own_pull;
   reg [15:0] ref_cnt;
   reg [15:0] tick_cnt;
   reg [15:0] pwm_div;
   reg [7:0] pwm_phase;
   reg [7:0] speed_duty;
   reg [23:0] boot_cnt;
   reg [15:0] next_auto;
   reg [7:0] next_duty;

   wire [SYNC_W-1:0] pin_raw;
   wire [SYNC_W-1:0] pin_sync;
   wire tacho_in_sync;
   wire thermal_limit_io_sync;
   wire scl_sync;
   wire sda_sync;
   wire [2:0] strap_sync;
   wire ref_tick;
   wire tacho_in_rise;
   wire pwm_step;
   wire pwm_wrap;
   wire ext_low;
   wire [15:0] div_sel;

   // tacho_in counter ran out without an edge
   function stalled;
      input [15:0] count;
      begin
         stalled = (count == `FAIL_COUNT);
      end
   endfunction

   // auto loop product clipped to the duty range
   function [7:0] saturate;
      input [15:0] value;
      begin
         if (value[15:8] != 8'h00)
            saturate = `DUTY_FULL;
         else
            saturate = value[7:0];
      end
   endfunction

   assign pin_raw = {freq_range_sel, addr_sel_hi, addr_sel_lo, smb_data_in, smb_clk_in,
      thermal_limit_in, tacho_in};
   assign tacho_in_sync = pin_sync[0];
   assign thermal_limit_io_sync = pin_sync[1];
   assign scl_sync = pin_sync[2];
   assign sda_sync = pin_sync[3];
   assign strap_sync = pin_sync[6:4];

   // every pin passes two flops before any logic sees it
   genvar g;
   generate
      for (g = 0; g < SYNC_W; g = g + 1) begin : sync_stage
         reg [1:0] pipe;
         always @(posedge mclk) begin
            pipe <= {pipe[0], pin_raw[g]};
         end
         assign pin_sync[g] = pipe[1];
      end
   endgenerate

   assign ref_tick = (ref_cnt == REF_DIV[15:0] - 16'h0001);
   assign tacho_in_rise = tacho_in_sync & ~tacho_in_d;
   assign div_sel = slow_range ? SLOW_DIV : FAST_DIV;
   assign pwm_step = (pwm_div == div_sel - 16'h0001);
   assign pwm_wrap = pwm_step & (pwm_phase == 8'hFF);
   // our own drive also pulls the pin; it is ignored while we drive and for the
   // synchroniser delay after, so an outside pull under our own drive goes unseen
   assign ext_low = ~thermal_limit_io_sync & ~thermal_limit_oe & (own_pull == 3'h0);

   always @(posedge mclk) begin
      tacho_in_d <= tacho_in_sync;
   end

   always @* begin
      next_auto = 16'h0000;
      if (temperature > auto_start_temp)
         next_auto = (temperature - auto_start_temp) * auto_slope;
      case (mode_sel)
         `MODE_SPEED: next_duty = speed_duty;
         `MODE_DIRECT: next_duty = host_duty;
         `MODE_AUTO: next_duty = saturate(next_auto);
         default: next_duty = host_duty;
      endcase
      if (ext_low)
         next_duty = `DUTY_FULL;
   end

   // straps, boot window, converter and bus sampling
   always @(posedge mclk) begin
      if (srst) begin
         strap_done <= 1'b0;
         slow_range <= 1'b1;
         bus_addr_sel <= 2'h0;
         boot_cnt <= 24'h000000;
         bus_ready <= 1'b0;
         conv_run <= 1'b0;
         smb_sync <= 2'h3;
         smb_data_oe <= 1'b0;
      end else begin
         // straps caught on the first clock after release, then frozen
         if (!strap_done) begin
            strap_done <= 1'b1;
            slow_range <= strap_sync[2];
            bus_addr_sel <= strap_sync[1:0];
         end
         conv_run <= conv_start;
         if (boot_cnt != BOOT_CYCLES[23:0] - 24'h000001)
            boot_cnt <= boot_cnt + 24'h000001;
         else
            bus_ready <= 1'b1;
         // bus lines sampled only once ready; protocol engine lives elsewhere
         smb_sync <= bus_ready ? {scl_sync, sda_sync} : 2'h3;
         smb_data_oe <= 1'b0;
      end
   end

   // tacho_in period in reference ticks, pinned at full scale when stalled
   always @(posedge mclk) begin
      if (srst) begin
         ref_cnt <= 16'h0000;
         tick_cnt <= 16'h0000;
         tacho_in_period <= 16'h0000;
      end else begin
         ref_cnt <= ref_tick ? 16'h0000 : ref_cnt + 16'h0001;
         if (tacho_in_rise) begin
            tacho_in_period <= tick_cnt;
            tick_cnt <= 16'h0000;
         end else if (ref_tick && !stalled(tick_cnt)) begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
         if (stalled(tick_cnt))
            tacho_in_period <= `FAIL_COUNT;
      end
   end

   // one step per reference tick keeps the loop slow and stable
   always @(posedge mclk) begin
      if (srst) begin
         speed_duty <= 8'h80;
      end else if (ref_tick && mode_sel == `MODE_SPEED) begin
         if (tacho_in_period > target_period && speed_duty != 8'hFF)
            speed_duty <= speed_duty + 8'h01;
         else if (tacho_in_period < target_period && speed_duty != 8'h00)
            speed_duty <= speed_duty - 8'h01;
      end
   end

   // duty changes only at a wrap, so no period is cut short
   always @(posedge mclk) begin
      if (srst) begin
         pwm_div <= 16'h0000;
         pwm_phase <= 8'h00;
         duty_now <= 8'h00;
         fan_drive_oe <= 1'b0;
      end else begin
         if (pwm_step) begin
            pwm_div <= 16'h0000;
            pwm_phase <= pwm_phase + 8'h01;
         end else begin
            pwm_div <= pwm_div + 16'h0001;
         end
         if (pwm_wrap)
            duty_now <= next_duty;
         // full duty never pulls low, zero always does
         fan_drive_oe <= (duty_now == 8'hFF) ? 1'b0 : (pwm_phase >= duty_now);
      end
   end

   // alarm pins
   always @(posedge mclk) begin
      if (srst) begin
         own_pull <= 3'h0;
         external_thermal_request_flag <= 1'b0;
         critical_temp_oe <= 1'b0;
         thermal_limit_oe <= 1'b0;
         fan_failure_oe <= 1'b0;
         smb_alert_oe <= 1'b0;
      end else begin
         own_pull <= {own_pull[1:0], thermal_limit_oe};
         if (ext_low)
            external_thermal_request_flag <= 1'b1;
         if (temp_valid) begin
            critical_temp_oe <= sensor_fault | (temperature >= critical_limit);
            thermal_limit_oe <= temperature > thermal_limit;
         end
         fan_failure_oe <= stalled(tick_cnt);
         smb_alert_oe <= alert_enable &
            (sensor_fault | temperature > alert_limit | stalled(tick_cnt));
      end
   end
endmodule
`default_nettype wire

// [tb/fan_props.sv]
`timescale 1ns/100ps
`default_nettype none
module fan_props (
   input wire mclk, srst, temp_valid, sensor_fault, conv_start, freq_range_sel, addr_sel_hi,
   input wire addr_sel_lo, thermal_limit_in, fan_drive_oe, critical_temp_oe, thermal_limit_oe,
   input wire fan_failure_oe, smb_alert_oe, smb_data_oe, conv_run, slow_range, bus_ready,
   input wire external_thermal_request_flag,
   input wire [7:0] temperature, critical_limit, thermal_limit, duty_now,
   input wire [1:0] bus_addr_sel, smb_sync
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // six samples cover the synchroniser and the own-drive blanking
   sequence ext_pull; (!thermal_limit_in && !thermal_limit_oe) [*6]; endsequence
   rst_release_a: assert property ($fell(srst) |-> !(fan_drive_oe | critical_temp_oe |
      thermal_limit_oe | fan_failure_oe | smb_alert_oe)) else $error("pin held after reset");
   strap_latch_a: assert property ($fell(srst) |=> slow_range == $past(freq_range_sel, 3) &&
      bus_addr_sel == $past({addr_sel_hi, addr_sel_lo}, 3)) else $error("strap not latched");
   strap_hold_a: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(slow_range) &&
      $stable(bus_addr_sel)) else $error("strap moved");
   flag_set_a: assert property (ext_pull |-> external_thermal_request_flag)
      else $error("pull not flagged");
   flag_hold_a: assert property (external_thermal_request_flag |=>
      external_thermal_request_flag) else $error("flag dropped");
   crit_alarm_a: assert property (temp_valid |=> critical_temp_oe ==
      $past(sensor_fault || temperature >= critical_limit)) else $error("critical alarm wrong");
   thermal_limit_io_alarm_a: assert property (temp_valid |=> thermal_limit_oe ==
      $past(temperature > thermal_limit)) else $error("thermal alarm wrong");
   boot_quiet_a: assert property (!bus_ready |-> smb_sync == 2'h3)
      else $error("bus seen during boot");
   data_free_a: assert property (!smb_data_oe) else $error("data line pulled");
   conv_follow_a: assert property (conv_run == $past(conv_start))
      else $error("converter run wrong");
   full_release_a: assert property (duty_now == 8'hFF |=> !fan_drive_oe)
      else $error("full duty pulled low");
   zero_pull_a: assert property (duty_now == 8'h00 |=> fan_drive_oe)
      else $error("zero duty released");
endmodule
bind thermal_fan_pwm_control fan_props u_props (.*);
`default_nettype wire

// [tb/fan_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fan_model (
   input wire fan_drive_oe, thermal_limit_oe, ext_pull,
   output logic tacho_in,
   output wire thermal_limit_in, fan_pin
);
   assign fan_pin = !fan_drive_oe;
   assign thermal_limit_in = !(thermal_limit_oe || ext_pull);
   // fan speed does not follow duty, so the speed loop must run to its limit
   initial begin
      tacho_in = 1'b1;
      forever begin
         #1960 tacho_in = 1'b0;
         #40 tacho_in = 1'b1;
      end
   end
endmodule
`default_nettype wire

// [tb/thermal_fan_pwm_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module thermal_fan_pwm_control_tb;
   logic mclk = 0, srst = 1, temp_valid = 0, sensor_fault = 0, conv_start = 0, ext_pull = 0;
   logic freq_range_sel = 0, addr_sel_hi = 1, addr_sel_lo = 0, alert_enable = 1;
   logic smb_clk_in = 1, smb_data_in = 0;
   logic [1:0] mode_sel = 2'h2;
   logic [7:0] host_duty = 0, temperature = 0, auto_start_temp = 8'h10, auto_slope = 8'h01;
   logic [7:0] critical_limit = 8'hFF, thermal_limit = 8'hFF, alert_limit = 8'h40;
   logic [15:0] target_period = 16'h0028;
   wire fan_drive_oe, critical_temp_oe, thermal_limit_oe, fan_failure_oe, smb_alert_oe;
   wire smb_data_oe, external_thermal_request_flag, slow_range, bus_ready, conv_run;
   wire tacho_in, thermal_limit_in, fan_pin;
   wire [15:0] tacho_in_period;
   wire [7:0] duty_now;
   wire [1:0] bus_addr_sel, smb_sync;
   logic [19:0] notes[$];
   int fail_count = 0, total_checks = 0;
   event look;
   thermal_fan_pwm_control #(.BOOT_CYCLES(100), .REF_DIV(10)) DUT (.*);
   fan_model u_fan (.fan_drive_oe, .thermal_limit_oe, .ext_pull, .tacho_in, .thermal_limit_in,
      .fan_pin);
   always #5 mclk = ~mclk;
   function logic [15:0] observe(input logic [3:0] s);
      case (s)
         0: observe = duty_now;
         1: observe = {slow_range, bus_addr_sel};
         2: observe = external_thermal_request_flag;
         3: observe = bus_ready;
         4: observe = {critical_temp_oe, thermal_limit_oe};
         5: observe = tacho_in_period > 16'h0012 && tacho_in_period < 16'h0016;
         7: observe = smb_sync;
         8: observe = conv_run;
         9: observe = {smb_alert_oe, fan_failure_oe};
         default: observe = duty_now < 8'h80;
      endcase
   endfunction
   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   always @(look) while (notes.size() > 0) begin
      check(observe(notes[0][19:16]), notes[0][15:0]);
      void'(notes.pop_front());
   end
   task note(input logic [3:0] s, input logic [15:0] e);
      notes.push_back({s, e});
      -> look;
   endtask
   // duty only lands at a pwm wrap, so allow more than one fast period
   task wait_duty(input logic [7:0] e);
      repeat (6000) if (duty_now !== e) @(negedge mclk);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #800us;
      fail_count++;
      report_and_stop;
   end
   initial begin
      void'($urandom(35));
      repeat (8) @(negedge mclk);
      srst = 0;
      @(negedge mclk);
      {freq_range_sel, addr_sel_hi, addr_sel_lo} = 3'h5;
      @(negedge mclk);
      note(1, 16'h0002);
      note(3, 16'h0000);
      repeat (110) @(negedge mclk);
      note(3, 16'h0001);
      note(7, 16'h0002);
      for (int i = 0; i < 4; i++) begin
         host_duty = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         conv_start = i[0];
         wait_duty(host_duty);
         note(0, {8'h00, host_duty});
         note(8, {15'h0000, i[0]});
      end
      mode_sel = 2'h0;
      temp_valid = 1;
      auto_slope = 8'($urandom_range(8, 1));
      temperature = 8'h14;
      wait_duty(auto_slope * 8'h04);
      note(0, 16'(auto_slope * 8'h04));
      note(9, 16'h0000);
      temperature = 8'hF0;
      wait_duty((auto_slope > 8'h01) ? 8'hFF : 8'hE0);
      note(0, (auto_slope > 8'h01) ? 16'h00FF : 16'h00E0);
      note(9, 16'h0002);
      note(5, 16'h0001);
      mode_sel = 2'h1;
      repeat (6000) if (duty_now >= 8'h80) @(negedge mclk);
      note(6, 16'h0001);
      ext_pull = 1;
      wait_duty(8'hFF);
      note(2, 16'h0001);
      note(0, 16'h00FF);
      ext_pull = 0;
      repeat (20) @(negedge mclk);
      note(2, 16'h0001);
      {critical_limit, thermal_limit} = 16'hA080;
      for (int i = 0; i < 8; i++) begin
         temperature = 8'($urandom);
         sensor_fault = (i == 7);
         @(negedge mclk);
         note(4, {14'h0, sensor_fault || temperature >= 8'hA0, temperature > 8'h80});
      end
      @(negedge mclk);
      report_and_stop;
   end
endmodule
`default_nettype wire
